/* hdl/match_based_pwm_timer.sv */
/*
 * Match based PWM timer: prescaler, timer/counter, seven match registers,
 * four capture inputs, single and double edge PWM outputs.
 * Assumes capture pins are asynchronous; configuration ports are synchronous.
 */
// Contract
// - 32-bit prescaler feeds 32-bit timer counting clock cycles.
// - Seven match registers drive up to six single or three double PWMs.
// - Four capture inputs latch timer value on edges, optional interrupt.
// - Cycle match register match resets the counter, setting common period.
// - Single-edge outputs rise at cycle start, fall on own match.
// - Extra single-edge output uses one match, double-edge uses two.
// - Double-edge output edges from two matches, either polarity.
// - Per match: continue, stop or reset, with optional interrupt.
// - Period and width any count; all outputs share one rate.
// - Software releases new match values; applied in step with outputs.
// - Without PWM mode it is a plain timer, no PWM waveforms.
`timescale 1ns/1ps
module match_based_pwm_timer #(
    parameter int WIDTH = 32
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire pwm_timer_pkg::timer_ctrl_s ctrl_i,
    input wire logic [WIDTH-1:0] prescale_limit_i,
    input wire logic [pwm_timer_pkg::NUM_MATCH*WIDTH-1:0] match_value_i,
    input wire logic [pwm_timer_pkg::NUM_MATCH-1:0] match_write_i,
    input wire logic [pwm_timer_pkg::NUM_MATCH-1:0] match_release_i,
    input wire logic [pwm_timer_pkg::NUM_MATCH*3-1:0] match_action_i,
    input wire logic [pwm_timer_pkg::NUM_PWM-1:0] pwm_out_enable_i,
    input wire logic [pwm_timer_pkg::NUM_PWM-1:0] pwm_double_i,
    input wire logic [pwm_timer_pkg::NUM_CAPTURE-1:0] capture_pin_i,
    input wire pwm_timer_pkg::cap_edge_s [pwm_timer_pkg::NUM_CAPTURE-1:0] capture_edge_i,
    input wire logic [pwm_timer_pkg::NUM_CAPTURE-1:0] capture_int_en_i,
    output logic [WIDTH-1:0] count_o,
    output logic [WIDTH-1:0] prescale_count_o,
    output logic [pwm_timer_pkg::NUM_CAPTURE*WIDTH-1:0] capture_value_o,
    output logic [pwm_timer_pkg::NUM_MATCH-1:0] match_event_o,
    output logic [pwm_timer_pkg::NUM_MATCH-1:0] match_int_o,
    output logic [pwm_timer_pkg::NUM_CAPTURE-1:0] capture_int_o,
    output logic [pwm_timer_pkg::NUM_PWM-1:0] pwm_o,
    output logic running_o
);
    import pwm_timer_pkg::*;

    logic [WIDTH-1:0] prescale_reg;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] shadow_reg [NUM_MATCH];
    logic [WIDTH-1:0] active_reg [NUM_MATCH];
    logic [NUM_MATCH-1:0] latch_reg;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] hit_reg;
    logic [NUM_PWM-1:0] pwm_reg;
    logic [NUM_CAPTURE-1:0] cap_s1_reg;
    logic [NUM_CAPTURE-1:0] cap_s2_reg;
    logic [NUM_CAPTURE-1:0] cap_s3_reg;
    logic [NUM_CAPTURE-1:0] cap_lvl_reg;
    logic [NUM_CAPTURE-1:0] cap_fire;
    logic [WIDTH-1:0] cap_reg [NUM_CAPTURE];
    logic [NUM_CAPTURE-1:0] cap_int_reg;
    logic [NUM_MATCH-1:0] mint_reg;
    logic tick;
    logic any_reset;
    logic any_stop;
    logic run;
    logic stop_reg;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and timer/counter
    assign run = ctrl_i.enable && !ctrl_i.counter_reset && !stop_reg;
    assign tick = run && (prescale_reg == prescale_limit_i);

    always_comb begin
        any_reset = 1'b0;
        any_stop = 1'b0;
        for (int m = 0; m < NUM_MATCH; m++) begin
            hit[m] = run && tick && (count_reg == active_reg[m]);
            any_reset |= hit[m] && match_action_i[m*3+ACT_RST_BIT];
            any_stop |= hit[m] && match_action_i[m*3+ACT_STOP_BIT];
        end
        // Cycle match always restarts the period in PWM mode
        if (ctrl_i.pwm_mode && hit[0]) begin
            any_reset = 1'b1;
        end
        if (any_reset) begin
            count_next = COUNT_RESET;
        end else begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prescale_reg <= COUNT_RESET;
        end else if (ctrl_i.counter_reset || tick) begin
            prescale_reg <= COUNT_RESET;
        end else if (run) begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= COUNT_RESET;
        end else if (ctrl_i.counter_reset) begin
            count_reg <= COUNT_RESET;
        end else if (tick) begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            running_o <= 1'b0;
        end else begin
            running_o <= run && !any_stop;
        end
    end

    // Stop action halts the timer until software drops enable
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_reg <= 1'b0;
        end else if (!ctrl_i.enable) begin
            stop_reg <= 1'b0;
        end else if (any_stop) begin
            stop_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match registers with shadow and release
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int m = 0; m < NUM_MATCH; m++) begin
                shadow_reg[m] <= MATCH_RESET;
                active_reg[m] <= MATCH_RESET;
            end
            latch_reg <= '0;
        end else begin
            for (int m = 0; m < NUM_MATCH; m++) begin
                if (match_write_i[m]) begin
                    shadow_reg[m] <= match_value_i[m*WIDTH +: WIDTH];
                end
                // Plain timer mode loads at once; PWM waits for the cycle
                if (!ctrl_i.pwm_mode && match_write_i[m]) begin
                    active_reg[m] <= match_value_i[m*WIDTH +: WIDTH];
                end else if (ctrl_i.pwm_mode && latch_reg[m] && tick && any_reset) begin
                    active_reg[m] <= shadow_reg[m];
                end
                if (ctrl_i.pwm_mode && latch_reg[m] && tick && any_reset) begin
                    latch_reg[m] <= match_release_i[m];
                end else if (match_release_i[m]) begin
                    latch_reg[m] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hit_reg <= '0;
            mint_reg <= '0;
        end else begin
            hit_reg <= hit;
            for (int m = 0; m < NUM_MATCH; m++) begin
                mint_reg[m] <= hit[m] && match_action_i[m*3+ACT_INT_BIT];
            end
        end
    end
    assign match_event_o = hit_reg;
    assign match_int_o = mint_reg;

    ////////////////////////////////////////////////////////////////////////
    // PWM outputs: channel n uses match n+1 (fall) and match n (rise) when double
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwm_reg <= '0;
        end else if (!ctrl_i.pwm_mode) begin
            pwm_reg <= '0;
        end else begin
            for (int n = 0; n < NUM_PWM; n++) begin
                if (!pwm_out_enable_i[n]) begin
                    pwm_reg[n] <= 1'b0;
                end else if (pwm_double_i[n] && n > 0) begin
                    if (hit[n+1]) begin
                        pwm_reg[n] <= 1'b0;
                    end else if (hit[n]) begin
                        pwm_reg[n] <= 1'b1;
                    end
                end else begin
                    if (hit[n+1]) begin
                        pwm_reg[n] <= 1'b0;
                    end else if (hit[0]) begin
                        pwm_reg[n] <= 1'b1;
                    end
                end
            end
        end
    end
    assign pwm_o = pwm_reg;

    ////////////////////////////////////////////////////////////////////////
    // Capture inputs
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_s1_reg <= '0;
            cap_s2_reg <= '0;
            cap_s3_reg <= '0;
            cap_lvl_reg <= '0;
        end else begin
            cap_s1_reg <= capture_pin_i;
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
            for (int c = 0; c < NUM_CAPTURE; c++) begin
                if (cap_s2_reg[c] == cap_s3_reg[c]) begin
                    cap_lvl_reg[c] <= cap_s3_reg[c];
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CAPTURE; c++) begin
            cap_fire[c] = (cap_s2_reg[c] == cap_s3_reg[c]) && (cap_s3_reg[c] != cap_lvl_reg[c]) &&
                ((cap_s3_reg[c] && capture_edge_i[c].rise) || (!cap_s3_reg[c] && capture_edge_i[c].fall));
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < NUM_CAPTURE; c++) begin
                cap_reg[c] <= COUNT_RESET;
            end
            cap_int_reg <= '0;
        end else begin
            for (int c = 0; c < NUM_CAPTURE; c++) begin
                if (cap_fire[c]) begin
                    cap_reg[c] <= count_reg;
                end
                cap_int_reg[c] <= cap_fire[c] && capture_int_en_i[c];
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CAPTURE; c++) begin
            capture_value_o[c*WIDTH +: WIDTH] = cap_reg[c];
        end
    end
    assign capture_int_o = cap_int_reg;
    assign count_o = count_reg;
    assign prescale_count_o = prescale_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_cycle_hit;
        ctrl_i.pwm_mode && hit[0] && !ctrl_i.counter_reset;
    endsequence

    a_period_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_cycle_hit |=> count_reg == COUNT_RESET)
        else $error("Cycle match did not reset counter");
    a_prescale_wrap: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        tick && !ctrl_i.counter_reset |=> prescale_reg == COUNT_RESET)
        else $error("Prescaler did not restart");
    a_count_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !tick && !ctrl_i.counter_reset |=> $stable(count_reg))
        else $error("Counter moved without tick");
    a_count_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        tick && !any_reset && !ctrl_i.counter_reset |=> count_reg == $past(count_reg) + 1'b1)
        else $error("Counter did not advance");
    a_single_rise: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_cycle_hit and (pwm_out_enable_i[0] && !pwm_double_i[0] && !hit[1]) |=> pwm_o[0])
        else $error("Single edge output did not rise");
    a_single_fall: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ctrl_i.pwm_mode && hit[1] |=> !pwm_o[0])
        else $error("Single edge output did not fall");
    a_plain_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !ctrl_i.pwm_mode |=> pwm_o == '0)
        else $error("PWM driven in timer mode");
    a_held_value: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ctrl_i.pwm_mode && !(tick && any_reset) |=> $stable(active_reg[1]))
        else $error("Match value changed mid cycle");
    a_capture_take: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        cap_fire[0] |=> cap_reg[0] == $past(count_reg))
        else $error("Capture did not store count");
endmodule

/* hdl/pwm_timer_pkg.sv */
/*
 * Package for the match based PWM timer: counts, reset values, carriers.
 * Assumes a single clock domain and plain-port configuration.
 */
package pwm_timer_pkg;
    localparam int NUM_MATCH = 7;
    localparam int NUM_CAPTURE = 4;
    localparam int NUM_PWM = 6;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
    localparam logic [2:0] ACT_RESET = 3'h0;
    localparam int ACT_INT_BIT = 0;
    localparam int ACT_RST_BIT = 1;
    localparam int ACT_STOP_BIT = 2;

    typedef struct packed {
        logic enable;
        logic counter_reset;
        logic pwm_mode;
    } timer_ctrl_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } cap_edge_s;
endpackage

/* verification/tb_match_based_pwm_timer.sv */
/*
 * Self-checking bench for the match based PWM timer: reset, single and double
 * edge PWM, release timing, prescaler, plain timer mode, match actions, capture.
 * Assumes the design's registered outputs and one 25 MHz clock.
 */
`timescale 1ns/1ps
module tb_match_based_pwm_timer;
    import pwm_timer_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    timer_ctrl_s ctrl_i = '0;
    logic [31:0] lim_i = '0;
    logic [NUM_MATCH*32-1:0] mval_i = '0;
    logic [NUM_MATCH-1:0] mwr_i = '0;
    logic [NUM_MATCH-1:0] mrel_i = '0;
    logic [NUM_MATCH*3-1:0] act_i = '0;
    logic [NUM_PWM-1:0] pen_i = '0;
    logic [NUM_PWM-1:0] pdbl_i = '0;
    logic [NUM_CAPTURE-1:0] cpin_i = '0;
    cap_edge_s [NUM_CAPTURE-1:0] cedge_i = '0;
    logic [NUM_CAPTURE-1:0] cint_en_i = '1;
    logic [31:0] count_o;
    logic [31:0] pcount_o;
    logic [NUM_CAPTURE*32-1:0] cval_o;
    logic [NUM_MATCH-1:0] mev_o;
    logic [NUM_MATCH-1:0] mint_o;
    logic [NUM_CAPTURE-1:0] cint_o;
    logic [NUM_PWM-1:0] pwm_o;
    logic running_o;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int hi, oth, ev, it, ci, rl;
    logic [31:0] maxc, maxp, c0, cap;

    match_based_pwm_timer i_match_based_pwm_timer (.mclk_i(mclk_i), .resetn_i(resetn_i), .ctrl_i(ctrl_i),
        .prescale_limit_i(lim_i), .match_value_i(mval_i), .match_write_i(mwr_i), .match_release_i(mrel_i),
        .match_action_i(act_i), .pwm_out_enable_i(pen_i), .pwm_double_i(pdbl_i), .capture_pin_i(cpin_i),
        .capture_edge_i(cedge_i), .capture_int_en_i(cint_en_i), .count_o(count_o), .prescale_count_o(pcount_o),
        .capture_value_o(cval_o), .match_event_o(mev_o), .match_int_o(mint_o), .capture_int_o(cint_o),
        .pwm_o(pwm_o), .running_o(running_o));

    always #20 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input int m, input logic [31:0] v, input logic rel);
        mval_i[m*32+:32] = v;
        mwr_i[m] = 1'b1;
        mrel_i[m] = rel;
        @(negedge mclk_i);
        mwr_i = '0;
        mrel_i = '0;
    endtask

    // Loads matches with the timer held, then starts it
    task automatic setup(input logic [31:0] lim, input logic [31:0] v0, v1, v2, input logic pm);
        @(negedge mclk_i);
        ctrl_i = '{enable: 1'b0, counter_reset: 1'b1, pwm_mode: 1'b0};
        lim_i = lim;
        wr(0, v0, 1'b1);
        wr(1, v1, 1'b1);
        wr(2, v2, 1'b1);
        ctrl_i = '{enable: 1'b1, counter_reset: 1'b0, pwm_mode: pm};
        repeat (12) @(negedge mclk_i);
    endtask

    task automatic measure(input int n, input int ch, input int m);
        hi = 0; oth = 0; ev = 0; it = 0; ci = 0; rl = 0; maxc = '0; maxp = '0;
        repeat (n) begin
            @(negedge mclk_i);
            hi += (pwm_o[ch] === 1'b1);
            oth += ((pwm_o & ~(6'h01 << ch)) !== '0);
            ev += (mev_o[0] === 1'b1);
            it += (mint_o[m] === 1'b1);
            ci += (cint_o[0] === 1'b1);
            rl += (running_o === 1'b0);
            if (count_o > maxc) maxc = count_o;
            if (pcount_o > maxp) maxp = pcount_o;
        end
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge mclk_i);
        check({count_o[3:0], pwm_o, mev_o, running_o}, '0);
        resetn_i = 1'b1;
        $display("test reset done");
        pen_i = 6'h01;
        setup(32'h0, 32'h3, 32'h1, 32'h0, 1'b1);
        measure(40, 0, 0);
        check(hi, 20);
        check(oth, 0);
        check(ev, 10);
        check(maxc, 32'h3);
        wr(1, 32'h2, 1'b0);
        measure(40, 0, 0);
        check(hi, 20);
        mrel_i[1] = 1'b1;
        @(negedge mclk_i);
        mrel_i = '0;
        repeat (8) @(negedge mclk_i);
        measure(40, 0, 0);
        check(hi, 30);
        $display("test single edge done");
        pen_i = 6'h02;
        pdbl_i = 6'h02;
        setup(32'h0, 32'h4, 32'h1, 32'h3, 1'b1);
        measure(50, 1, 0);
        check(hi, 20);
        wr(1, 32'h3, 1'b1);
        wr(2, 32'h1, 1'b1);
        repeat (10) @(negedge mclk_i);
        measure(50, 1, 0);
        check(hi, 30);
        $display("test double edge done");
        pdbl_i = '0;
        pen_i = 6'h03;
        setup(32'h1, 32'h3, 32'h1, 32'h0, 1'b1);
        measure(32, 0, 0);
        check(hi, 16);
        check(ev, 4);
        check(maxp, 32'h1);
        check(oth, 8);
        $display("test prescaler done");
        pen_i = '1;
        act_i = {9'h0, 3'h1, 3'h4, 3'h0, 3'h3};
        setup(32'h0, 32'h4, 32'h0, 32'h7, 1'b0);
        wr(3, 32'h1, 1'b1);
        measure(40, 0, 3);
        check(hi + oth, 0);
        check(ev, 8);
        check(it, 8);
        check(rl, 0);
        check(maxc, 32'h4);
        // Stop match now inside the period: timer halts one count past it
        wr(2, 32'h2, 1'b1);
        measure(8, 0, 3);
        measure(8, 0, 3);
        check(ev + it, 0);
        check(rl, 8);
        check(maxc, 32'h3);
        check(count_o, 32'h3);
        $display("test plain timer done");
        act_i = '0;
        cedge_i[0].rise = 1'b1;
        setup(32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
        c0 = count_o;
        cpin_i[0] = 1'b1;
        measure(8, 0, 0);
        cap = cval_o[31:0];
        check((cap - c0) < 32'h8, 32'h1);
        check(ci, 1);
        cpin_i[0] = 1'b0;
        measure(8, 0, 0);
        check(cval_o[31:0], cap);
        check(ci, 0);
        $display("test capture done");
        print_verdict();
    end
endmodule
